/* rtl/mic_irq_ctrl.sv */
// Interrupt controller of an 8-bit microcontroller with APB register access
`timescale 1ns/1ns
`default_nettype none
module mic_irq_ctrl
   import mic_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_irq_pin,
   input  wire logic        t0_overflow,
   input  wire logic        port_change,
   input  wire logic        conversion_done,
   input  wire logic        t1_overflow,
   input  wire logic        t2_match,
   input  wire logic        capcmp_event,
   input  wire logic [3:0]  capcmp_mode_field,
   input  wire logic        serial_port_event,
   input  wire logic        display_fetch_done,
   input  wire logic        first_common_line,
   input  wire logic        instr_boundary,
   input  wire logic        return_from_isr_op,
   input  wire logic        sleeping,
   output logic             core_irq_take,
   output logic [12:0]      vector_pc,
   output logic             stack_push,
   output logic             wake_up,
   output logic             t1_reset,
   output logic             frame_start,
   output logic             irq
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   // Register images are at most one byte wide;
   // the bus shows them in bits 7:0 and
   // reads zero above. In every flag a
   // hardware set beats a software clear,
   // so an event on a write is not lost.

   logic [7:0] irq_control;           // Enables, masks and core flags
   logic [7:0] peripheral_irq_flags;  // Peripheral flags
   logic [7:0] peripheral_irq_masks;  // Peripheral masks
   logic [3:0] event_status;          // Sticky block events
   logic [3:0] event_mask;            // Mask for irq output
   logic [1:0] ext_wait;              // Countdown for pin/port latency
   logic       ext_pending;           // Pin/port event awaiting latency
   logic       prev_ext_pin;          // Edge detector for pin
   logic       prev_com;              // Edge detector for common line
   logic       in_service;            // Core is inside a service routine

   // ---------------------------------------------------------------
   // Combinational decode
   // ---------------------------------------------------------------
   logic       wr_access;             // Write takes effect this edge
   logic [7:0] periph_set;            // Peripheral set pulses
   logic       ext_edge;              // Rising edge on pin
   logic       core_pending;          // Control flag/mask pair active
   logic       periph_pending;        // Peripheral flag/mask pair active
   logic       request;               // Gated request to core
   logic       ext_ready;             // Pin/port latency satisfied
   logic       accept;                // Request accepted this cycle
   logic       special_trig;          // Compare special event

   // Writes land in the access phase;
   // reads use data caught at setup.
   assign wr_access = psel & penable & pwrite;
   assign ext_edge  = ext_irq_pin & ~prev_ext_pin;
   assign special_trig = capcmp_event & (capcmp_mode_field == SPECIAL_TRIGGER);

   // Source pulses are one cycle wide; a
   // source held high, other than the pin,
   // sets its flag each cycle, harmless as flags are sticky.
   // The compare unit keeps its own flag
   // when it fires the special trigger.

   // Peripheral set vector; the special trigger never sets timer1 flag
   always_comb begin
      periph_set = 8'h00;
      periph_set[BIT_T1]      = t1_overflow & ~special_trig;
      periph_set[BIT_T2]      = t2_match;
      periph_set[BIT_CAPCMP]  = capcmp_event;
      periph_set[BIT_SERIAL]  = serial_port_event;
      periph_set[BIT_CONV]    = conversion_done;
      periph_set[BIT_DISPLAY] = display_fetch_done;
   end

   // Pending pairs and request gating
   assign core_pending =
      (irq_control[BIT_T0_FLAG]   & irq_control[BIT_T0_MASK])   |
      (irq_control[BIT_EXT_FLAG]  & irq_control[BIT_EXT_MASK])  |
      (irq_control[BIT_PORT_FLAG] & irq_control[BIT_PORT_MASK]);
   assign periph_pending = |(peripheral_irq_flags & peripheral_irq_masks);
   assign request = irq_control[BIT_GLOBAL_EN] &
                    (core_pending |
                     (irq_control[BIT_PERIPH_EN] & periph_pending));
   // A request is taken at an instruction
   // boundary, or at once while the core
   // sleeps, and never inside a running
   // routine: only the return reopens it.

   // Pin/port requests only go once the latency pipeline has run
   assign ext_ready = ~ext_pending;
   assign accept = request & ext_ready & (instr_boundary | sleeping) &
                   ~in_service;

   // ---------------------------------------------------------------
   // Control register: flags, masks, global enable
   // ---------------------------------------------------------------
   // Global enable: reset clears it, a
   // take clears it, the return op sets
   // it. A write in the cycle of a take
   // still leaves the enable cleared, so
   // no routine starts with it open.

   // Write first, then hardware sets win over a cleared bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_control <= RST_IRQ_CONTROL;
      end else begin
         if (wr_access && paddr == ADDR_IRQ_CONTROL) begin
            irq_control <= pwdata[7:0];
            if (accept) begin
               irq_control[BIT_GLOBAL_EN] <= 1'b0;
            end
         end else if (accept) begin
            irq_control[BIT_GLOBAL_EN] <= 1'b0;
         end else if (return_from_isr_op) begin
            irq_control[BIT_GLOBAL_EN] <= 1'b1;
         end
         if (t0_overflow) begin
            irq_control[BIT_T0_FLAG] <= 1'b1;
         end
         if (ext_edge) begin
            irq_control[BIT_EXT_FLAG] <= 1'b1;
         end
         if (port_change) begin
            irq_control[BIT_PORT_FLAG] <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Peripheral flag and mask registers
   // ---------------------------------------------------------------
   // Bits 5:4 have no source; they are
   // held at zero and read back as zero.

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_periph
         // One flag bit per source; set beats a software clear
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               peripheral_irq_flags[gi] <= RST_PERIPH[gi];
            end else if (!PERIPH_IMPL[gi]) begin
               peripheral_irq_flags[gi] <= 1'b0;
            end else if (periph_set[gi]) begin
               peripheral_irq_flags[gi] <= 1'b1;
            end else if (wr_access && paddr == ADDR_PERIPH_FLAGS) begin
               peripheral_irq_flags[gi] <= pwdata[gi];
            end
         end
      end
   endgenerate

   // Mask register, plain storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peripheral_irq_masks <= RST_PERIPH;
      end else if (wr_access && paddr == ADDR_PERIPH_MASKS) begin
         peripheral_irq_masks <= pwdata[7:0] & PERIPH_IMPL;
      end
   end

   // ---------------------------------------------------------------
   // External event latency pipeline
   // ---------------------------------------------------------------
   // Pin and port-change requests pass
   // this short pipeline so their latency
   // is three cycles plus, while awake, the
   // wait for the next instruction boundary.
   // A new event restarts the count.

   // Holds pin/port requests so service starts three to four cycles later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_wait    <= 2'h0;
         ext_pending <= 1'b0;
      end else if (ext_edge || port_change) begin
         ext_wait    <= EXT_LATENCY;
         ext_pending <= 1'b1;
      end else if (ext_wait != 2'h0) begin
         ext_wait    <= ext_wait - 2'h1;
      end else begin
         ext_pending <= 1'b0;
      end
   end

   // Edge detectors for pin and display common line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ext_pin <= 1'b0;
         prev_com     <= 1'b0;
      end else begin
         prev_ext_pin <= ext_irq_pin;
         prev_com     <= first_common_line;
      end
   end

   // ---------------------------------------------------------------
   // Core-facing outputs
   // ---------------------------------------------------------------
   // Take, push and vector are one-cycle
   // pulses that stand together; the
   // vector reads zero at all other times
   // so no stale address reaches the core.

   // Service tracking, vector and push pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_service    <= 1'b0;
         core_irq_take <= 1'b0;
         stack_push    <= 1'b0;
         vector_pc     <= 13'h0000;
      end else begin
         core_irq_take <= accept;
         stack_push    <= accept;
         vector_pc     <= accept ? IRQ_VECTOR : 13'h0000;
         if (accept) begin
            in_service <= 1'b1;
         end else if (return_from_isr_op) begin
            in_service <= 1'b0;
         end
      end
   end

   // Wake is a level while the core
   // sleeps with a masked-in pair set;
   // it changes no enable and no flag.
   // Frame start marks a rising edge.

   // Wake level, timer1 reset and frame start pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_up     <= 1'b0;
         t1_reset    <= 1'b0;
         frame_start <= 1'b0;
      end else begin
         // Any masked-in pair wakes, global enable ignored; flags untouched
         wake_up     <= sleeping & (core_pending | periph_pending);
         t1_reset    <= special_trig;
         frame_start <= first_common_line & ~prev_com;
      end
   end

   // ---------------------------------------------------------------
   // Event status, mask and interrupt line
   // ---------------------------------------------------------------
   // Block events for a host that watches
   // the controller over the bus: accept,
   // return, wake and display fetch done.

   logic [3:0] ev_set;   // Event pulses
   always_comb begin
      ev_set = 4'h0;
      ev_set[EV_ACCEPT] = accept;
      ev_set[EV_RETURN] = return_from_isr_op;
      ev_set[EV_WAKE]   = sleeping & (core_pending | periph_pending);
      ev_set[EV_FRAME]  = display_fetch_done;
   end

   // Write-one-to-clear; a new event beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_status <= 4'h0;
         event_mask   <= 4'h0;
      end else begin
         if (wr_access && paddr == ADDR_EVENT_STATUS) begin
            event_status <= (event_status & ~pwdata[3:0]) | ev_set;
         end else begin
            event_status <= event_status | ev_set;
         end
         if (wr_access && paddr == ADDR_EVENT_MASK) begin
            event_mask <= pwdata[3:0];
         end
      end
   end

   // The line is registered, so it rises
   // one cycle after the event is stored.

   // Level interrupt output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(event_status & event_mask);
      end
   end

   // ---------------------------------------------------------------
   // APB slave: zero wait states, error on unmapped address
   // ---------------------------------------------------------------
   logic        addr_hit;   // Address maps to a register
   logic [31:0] rd_mux;     // Read data selection
   always_comb begin
      addr_hit = 1'b1;
      rd_mux   = 32'h0000_0000;
      case (paddr)
         ADDR_IRQ_CONTROL:  rd_mux = {24'h000000, irq_control};
         ADDR_PERIPH_FLAGS: rd_mux = {24'h000000, peripheral_irq_flags};
         ADDR_PERIPH_MASKS: rd_mux = {24'h000000, peripheral_irq_masks};
         ADDR_EVENT_STATUS: rd_mux = {28'h0000000, event_status};
         ADDR_EVENT_MASK:   rd_mux = {28'h0000000, event_mask};
         ADDR_CORE_STATUS:  rd_mux = {30'h00000000, ext_pending, in_service};
         default:           addr_hit = 1'b0;
      endcase
   end

   // Every transfer has one access cycle.
   // An unmapped address answers with an
   // error and a write to it is dropped;
   // read data are zero outside a read.

   // Answer registered in the setup cycle so pready is high in access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_hit;
         prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // Limits: one vector serves all
   // sources, so the routine polls the
   // flags; no priority and no nesting.

endmodule // mic_irq_ctrl
`default_nettype wire

/* rtl/mic_pkg.sv */
// Package of register offsets, bit positions and constants for the interrupt controller
package mic_pkg;
   // ---------------------------------------------------------------
   // Register byte addresses
   // ---------------------------------------------------------------
   // Printed offsets are not all multiples of four, so they are indices
   localparam logic [7:0]  IDX_IRQ_CONTROL   = 8'h0b;  // Control register index
   localparam logic [7:0]  IDX_PERIPH_FLAGS  = 8'h0c;  // Peripheral flag index
   localparam logic [7:0]  IDX_PERIPH_MASKS  = 8'h8c;  // Peripheral mask index
   localparam logic [7:0]  IDX_EVENT_STATUS  = 8'h40;  // Event status index
   localparam logic [7:0]  IDX_EVENT_MASK    = 8'h41;  // Event mask index
   localparam logic [7:0]  IDX_CORE_STATUS   = 8'h42;  // Core status index
   localparam logic [11:0] ADDR_IRQ_CONTROL  = {2'h0, IDX_IRQ_CONTROL, 2'h0};
   localparam logic [11:0] ADDR_PERIPH_FLAGS = {2'h0, IDX_PERIPH_FLAGS, 2'h0};
   localparam logic [11:0] ADDR_PERIPH_MASKS = {2'h0, IDX_PERIPH_MASKS, 2'h0};
   localparam logic [11:0] ADDR_EVENT_STATUS = {2'h0, IDX_EVENT_STATUS, 2'h0};
   localparam logic [11:0] ADDR_EVENT_MASK   = {2'h0, IDX_EVENT_MASK, 2'h0};
   localparam logic [11:0] ADDR_CORE_STATUS  = {2'h0, IDX_CORE_STATUS, 2'h0};

   // ---------------------------------------------------------------
   // Control register bits
   // ---------------------------------------------------------------
   localparam int BIT_GLOBAL_EN   = 7;
   localparam int BIT_PERIPH_EN   = 6;
   localparam int BIT_T0_MASK     = 5;
   localparam int BIT_EXT_MASK    = 4;
   localparam int BIT_PORT_MASK   = 3;
   localparam int BIT_T0_FLAG     = 2;
   localparam int BIT_EXT_FLAG    = 1;
   localparam int BIT_PORT_FLAG   = 0;
   // Peripheral bits (flag and mask share layout)
   localparam int BIT_T1          = 0;
   localparam int BIT_T2          = 1;
   localparam int BIT_CAPCMP      = 2;
   localparam int BIT_SERIAL      = 3;
   localparam int BIT_CONV        = 6;
   localparam int BIT_DISPLAY     = 7;
   localparam logic [7:0] PERIPH_IMPL = 8'hcf;    // Bits 5:4 read zero

   // ---------------------------------------------------------------
   // Reset values and misc
   // ---------------------------------------------------------------
   localparam logic [7:0]  RST_IRQ_CONTROL = 8'h00;
   localparam logic [7:0]  RST_PERIPH      = 8'h00;
   localparam logic [12:0] IRQ_VECTOR      = 13'h0004;
   localparam logic [3:0]  SPECIAL_TRIGGER = 4'hb;  // Compare mode 1011
   localparam int          NUM_SOURCES     = 9;
   // External event pipeline length: taken 3 to 4 cycles after event
   localparam logic [1:0]  EXT_LATENCY     = 2'h1;
   // Event status bits
   localparam int EV_ACCEPT  = 0;
   localparam int EV_RETURN  = 1;
   localparam int EV_WAKE    = 2;
   localparam int EV_FRAME   = 3;
endpackage : mic_pkg

/* bench/mic_irq_monitor.sv */
// Checker of the interrupt controller port behaviour
`timescale 1ns/1ns
`default_nettype none
module mic_irq_monitor
   import mic_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        capcmp_event,
   input wire logic [3:0]  capcmp_mode_field,
   input wire logic        first_common_line,
   input wire logic        sleeping,
   input wire logic        core_irq_take,
   input wire logic [12:0] vector_pc,
   input wire logic        stack_push,
   input wire logic        wake_up,
   input wire logic        t1_reset,
   input wire logic        frame_start
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_take_vector: assert property (core_irq_take |-> vector_pc == IRQ_VECTOR && stack_push)
      else $error("take without vector or push");
   a_idle_vector: assert property (!core_irq_take |-> vector_pc == 13'h0 && !stack_push)
      else $error("vector shown outside take");
   a_take_spacing: assert property (core_irq_take |=> (!core_irq_take)[*2])
      else $error("second take too soon");
   a_reset_gie: assert property (!$past(presetn) |-> !core_irq_take)
      else $error("take right after reset");
   a_special_trig: assert property (capcmp_event && capcmp_mode_field == 4'hb |=> t1_reset)
      else $error("timer reset missing");
   a_frame_edge: assert property (frame_start |-> $past(first_common_line) && !$past(first_common_line, 2))
      else $error("frame start without line edge");
   a_wake_sleep: assert property (wake_up |-> $past(sleeping))
      else $error("wake while awake");
   a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("access cycle not one cycle");
   // Main scenarios reached
   c_take: cover property (core_irq_take);
   c_wake: cover property (wake_up && !core_irq_take);
   c_frame: cover property (frame_start);
endmodule // mic_irq_monitor
bind mic_irq_ctrl mic_irq_monitor mic_irq_monitor_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pready(pready), .capcmp_event(capcmp_event),
   .capcmp_mode_field(capcmp_mode_field), .first_common_line(first_common_line),
   .sleeping(sleeping), .core_irq_take(core_irq_take), .vector_pc(vector_pc),
   .stack_push(stack_push), .wake_up(wake_up), .t1_reset(t1_reset),
   .frame_start(frame_start));
`default_nettype wire

/* bench/mic_core_model.sv */
// Behavioural core model giving instruction boundaries and returns
`timescale 1ns/1ns
`default_nettype none
module mic_core_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic core_irq_take,
   input  wire logic slow,
   input  wire logic ret_cmd,
   output logic      instr_boundary,
   output logic      return_from_isr_op
);
   logic in_isr; // Core is running service code
   // Two-cycle instructions open a boundary every other cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_boundary <= 1'b0;
      end else begin
         instr_boundary <= slow ? ~instr_boundary : 1'b1;
      end
   end
   // A return only leaves a routine that was entered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_isr <= 1'b0;
         return_from_isr_op <= 1'b0;
      end else begin
         return_from_isr_op <= ret_cmd && in_isr;
         if (core_irq_take) begin
            in_isr <= 1'b1;
         end else if (ret_cmd) begin
            in_isr <= 1'b0;
         end
      end
   end
endmodule // mic_core_model
`default_nettype wire

/* bench/mic_irq_ctrl_tb.sv */
// Self-checking testbench of the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module mic_irq_ctrl_tb;
   import mic_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, rnd;
   logic [8:0]  ev;         // Source pulses, peripheral bit order
   logic [3:0]  mode;       // Compare mode
   logic        fcl, sleeping, slow, ret_cmd, ib, rfi;
   logic        take, push, wake, t1r, fst, irq;
   logic [12:0] vpc;
   logic [7:0]  e_ctrl, e_pf, e_pm; // Register model
   int          n_errors, checks, n;
   mic_irq_ctrl mic_irq_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_irq_pin(ev[8]), .t0_overflow(ev[4]),
      .port_change(ev[5]), .conversion_done(ev[6]), .t1_overflow(ev[0]), .t2_match(ev[1]),
      .capcmp_event(ev[2]), .capcmp_mode_field(mode), .serial_port_event(ev[3]),
      .display_fetch_done(ev[7]), .first_common_line(fcl), .instr_boundary(ib),
      .return_from_isr_op(rfi), .sleeping(sleeping), .core_irq_take(take), .vector_pc(vpc),
      .stack_push(push), .wake_up(wake), .t1_reset(t1r), .frame_start(fst), .irq(irq));
   mic_core_model mic_core_model_i (.pclk(pclk), .presetn(presetn), .core_irq_take(take),
      .slow(slow), .ret_cmd(ret_cmd), .instr_boundary(ib), .return_from_isr_op(rfi));
   // ---------------------------------------------------------------
   // Clock, helpers and bus tasks
   // ---------------------------------------------------------------
   initial pclk = 1'b0;
   always #5 pclk = ~pclk;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
      if (a == ADDR_IRQ_CONTROL) e_ctrl = d;
      if (a == ADDR_PERIPH_FLAGS) e_pf = d & PERIPH_IMPL;
      if (a == ADDR_PERIPH_MASKS) e_pm = d & PERIPH_IMPL;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      chk(r, {24'h0, e});
   endtask
   // One-cycle source pulse and its flag in the model
   task automatic fire(input int i);
      @(posedge pclk) ev[i] <= 1'b1;
      @(posedge pclk) ev[i] <= 1'b0;
      if (i == 4) e_ctrl[BIT_T0_FLAG] = 1'b1;
      else if (i == 5) e_ctrl[BIT_PORT_FLAG] = 1'b1;
      else if (i == 8) e_ctrl[BIT_EXT_FLAG] = 1'b1;
      else e_pf[i] = 1'b1;
   endtask
   task automatic quiet(input int c);
      repeat (c) begin
         @(posedge pclk);
         chk({31'h0, take}, 32'h0);
      end
   endtask
   // Service one request: vector, clear flags, return
   task automatic serve(input logic [11:0] fa, input logic [7:0] v);
      n = 0;
      while (take !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, take}, 32'h1);
      chk({19'h0, vpc}, 32'h4);
      e_ctrl[BIT_GLOBAL_EN] = 1'b0;
      rd(ADDR_IRQ_CONTROL, e_ctrl);
      wr(fa, v);
      @(posedge pclk) ret_cmd <= 1'b1;
      @(posedge pclk) ret_cmd <= 1'b0;
      e_ctrl[BIT_GLOBAL_EN] = 1'b1;
      rd(ADDR_IRQ_CONTROL, e_ctrl);
   endtask
   task automatic print_verdict();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      print_verdict();
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, ev, mode} = '0;
      {fcl, sleeping, slow, ret_cmd, presetn} = '0;
      {e_ctrl, e_pf, e_pm} = '0;
      n_errors = 0;
      checks = 0;
      rnd = 32'hec91;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_IRQ_CONTROL, 8'h00);
      rd(ADDR_PERIPH_FLAGS, 8'h00);
      rd(ADDR_PERIPH_MASKS, 8'h00);
      apb(1'b0, 12'h004, 32'h0);
      chk({31'h0, er}, 32'h1);
      for (int i = 0; i < 4; i++) begin
         rnd = xs(rnd);
         wr(ADDR_PERIPH_MASKS, rnd[7:0]);
         wr(ADDR_PERIPH_FLAGS, rnd[15:8]);
         rd(ADDR_PERIPH_MASKS, e_pm);
         rd(ADDR_PERIPH_FLAGS, e_pf);
      end
      wr(ADDR_PERIPH_MASKS, 8'h00);
      wr(ADDR_PERIPH_FLAGS, 8'h00);
      for (int i = 0; i < NUM_SOURCES; i++) fire(i);
      rd(ADDR_IRQ_CONTROL, e_ctrl);
      rd(ADDR_PERIPH_FLAGS, e_pf);
      wr(ADDR_IRQ_CONTROL, 8'h00);
      wr(ADDR_PERIPH_FLAGS, 8'h00);
      mode <= SPECIAL_TRIGGER;
      // Overflow in the trigger cycle must not raise the timer1 flag
      @(posedge pclk) {ev[0], ev[2]} <= 2'b11;
      @(posedge pclk) {ev[0], ev[2]} <= 2'b00;
      e_pf[BIT_CAPCMP] = 1'b1;
      @(posedge pclk);
      chk({31'h0, t1r}, 32'h1);
      rd(ADDR_PERIPH_FLAGS, e_pf);
      mode <= 4'h0;
      @(posedge pclk) fcl <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({31'h0, fst}, 32'h1);
      fcl <= 1'b0;
      wr(ADDR_PERIPH_FLAGS, 8'h00);
      wr(ADDR_PERIPH_MASKS, 8'h08);
      wr(ADDR_IRQ_CONTROL, 8'h40);
      fire(3);
      quiet(8);
      wr(ADDR_IRQ_CONTROL, 8'hc0);
      serve(ADDR_PERIPH_FLAGS, 8'h00);
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_EVENT_MASK, i == 0 ? 8'h03 : 8'h00);
         repeat (2) @(posedge pclk);
         chk({31'h0, irq}, i == 0 ? 32'h1 : 32'h0);
      end
      wr(ADDR_EVENT_MASK, 8'h03);
      wr(ADDR_EVENT_STATUS, 8'h0f);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      rd(ADDR_EVENT_STATUS, 8'h00);
      wr(ADDR_IRQ_CONTROL, 8'h80);
      fire(3);
      quiet(8);
      wr(ADDR_IRQ_CONTROL, 8'h00);
      wr(ADDR_PERIPH_FLAGS, 8'h00);
      for (int i = 0; i < 3; i++) begin
         slow <= (i == 1);
         sleeping <= (i == 2);
         wr(ADDR_IRQ_CONTROL, 8'h90);
         @(posedge pclk) ev[8] <= 1'b1;
         n = 0;
         while (take !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
         end
         // Pin sampled one edge in, take seen one edge late: 3 or 4
         chk({31'h0, n >= 5 && n <= 6}, 32'h1);
         ev[8] <= 1'b0;
         e_ctrl[BIT_EXT_FLAG] = 1'b1;
         serve(ADDR_IRQ_CONTROL, 8'h10);
         sleeping <= 1'b0;
      end
      slow <= 1'b0;
      sleeping <= 1'b1;
      wr(ADDR_IRQ_CONTROL, 8'h08);
      fire(5);
      n = 0;
      while (wake !== 1'b1 && n < 10) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, wake}, 32'h1);
      quiet(4);
      rd(ADDR_IRQ_CONTROL, e_ctrl);
      sleeping <= 1'b0;
      print_verdict();
   end
endmodule // mic_irq_ctrl_tb
`default_nettype wire
